// File: logic/rct_pkg.sv
// Shared constants and types for the reload/capture 16-bit timer.
// Assumes a single system clock domain; no bus, control arrives as a struct.
package rct_pkg;

    // Prescaler ratios for the two divided count sources
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;

    // Byte and word values at the wrap points and reset values
    localparam logic [7:0]  BYTE_MAX   = 8'hFF;
    localparam logic [7:0]  COUNT_RST  = 8'h00;
    localparam logic [7:0]  RELOAD_RST = 8'h00;
    localparam logic [15:0] WORD_MAX   = 16'hFFFF;

    // Software control bits, one field per control bit
    typedef struct packed {
        logic timer_irq_enable;
        logic low_overflow_irq_enable;
        logic capture_enable;
        logic split_mode_enable;
        logic run_control;
        logic capture_source_select;
        logic external_clock_select;
        logic high_byte_clock_select;
        logic low_byte_clock_select;
    } rct_ctrl_t;

    // Two count or reload bytes
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } rct_pair_t;

    // Operating modes
    typedef enum logic [3:0] {
        RCT_MODE_AR16  = 4'b0001,
        RCT_MODE_SPLIT = 4'b0010,
        RCT_MODE_CAP16 = 4'b0100,
        RCT_MODE_CAPSP = 4'b1000
    } rct_mode_t;

endpackage

// File: logic/rct_timer.sv
// Reload/capture 16-bit timer: counters, prescalers, capture and flags.
// Assumes all inputs synchronous to clk except the external oscillator
// and low-frequency oscillator levels, which are synchronised here.
`timescale 1ns/10ps
module rct_timer #(
    parameter int SYS_DIV = rct_pkg::SYS_DIV,
    parameter int EXT_DIV = rct_pkg::EXT_DIV
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire rct_pkg::rct_ctrl_t ctrl,
    input  wire logic              count_wr,
    input  wire rct_pkg::rct_pair_t count_wdata,
    input  wire logic              reload_wr,
    input  wire rct_pkg::rct_pair_t reload_wdata,
    input  wire logic              high_flag_clear,
    input  wire logic              low_flag_clear,
    input  wire logic              ext_osc_clk,
    input  wire logic              usb_sof,
    input  wire logic              low_freq_osc,
    output logic [7:0]             count_low_byte,
    output logic [7:0]             count_high_byte,
    output logic [7:0]             reload_low_byte,
    output logic [7:0]             reload_high_byte,
    output logic                   high_overflow_flag,
    output logic                   low_overflow_flag,
    output logic                   timer_irq
);

    localparam int SW = $clog2(SYS_DIV);
    localparam int EW = $clog2(EXT_DIV);

    // Refuse ratios the prescalers cannot serve
    if (SYS_DIV < 2 || EXT_DIV < 2) begin : g_bad_div
        $error("rct_timer: divider ratios must be at least 2");
    end

    // Reset release
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Prescalers and synchronisers
    logic [SW-1:0] sys_cnt_q, sys_cnt_d;
    logic [EW-1:0] ext_cnt_q, ext_cnt_d;
    logic          sys_tick_q, sys_tick_d;
    logic          ext_tick_q, ext_tick_d;
    logic [2:0]    ext_sync_q, ext_sync_d;
    logic [2:0]    lfo_sync_q, lfo_sync_d;
    logic          ext_rise;
    logic          lfo_fall;

    always_comb begin
        ext_sync_d = {ext_sync_q[1:0], ext_osc_clk};
        lfo_sync_d = {lfo_sync_q[1:0], low_freq_osc};
        ext_rise   = ext_sync_q[1] & ~ext_sync_q[2];
        lfo_fall   = lfo_sync_q[2] & ~lfo_sync_q[1];
        sys_tick_d = (sys_cnt_q == SW'(SYS_DIV - 1));
        sys_cnt_d  = sys_tick_d ? '0 : sys_cnt_q + SW'(1);
        ext_tick_d = ext_rise && (ext_cnt_q == EW'(EXT_DIV - 1));
        ext_cnt_d  = ext_cnt_q;
        if (ext_rise) begin
            ext_cnt_d = ext_tick_d ? '0 : ext_cnt_q + EW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_cnt_q  <= '0;
            ext_cnt_q  <= '0;
            sys_tick_q <= 1'b0;
            ext_tick_q <= 1'b0;
            ext_sync_q <= '0;
            lfo_sync_q <= '0;
        end else begin
            sys_cnt_q  <= sys_cnt_d;
            ext_cnt_q  <= ext_cnt_d;
            sys_tick_q <= sys_tick_d;
            ext_tick_q <= ext_tick_d;
            ext_sync_q <= ext_sync_d;
            lfo_sync_q <= lfo_sync_d;
        end
    end

    // Count enable for one byte from its clock select
    function automatic logic src_tick(input logic sel_sys, input logic sel_ext,
                                      input logic tick12, input logic tick8);
        src_tick = sel_sys ? 1'b1 : (sel_ext ? tick8 : tick12);
    endfunction

    function automatic rct_pkg::rct_mode_t mode_of(input rct_pkg::rct_ctrl_t c);
        case ({c.capture_enable, c.split_mode_enable})
            2'b00:   mode_of = rct_pkg::RCT_MODE_AR16;
            2'b01:   mode_of = rct_pkg::RCT_MODE_SPLIT;
            2'b10:   mode_of = rct_pkg::RCT_MODE_CAP16;
            default: mode_of = rct_pkg::RCT_MODE_CAPSP;
        endcase
    endfunction

    // Counter, reload, flags and interrupt
    rct_pkg::rct_pair_t count_q, count_d;
    rct_pkg::rct_pair_t reload_q, reload_d;
    logic               hflag_q, hflag_d;
    logic               lflag_q, lflag_d;
    logic               irq_q, irq_d;
    rct_pkg::rct_mode_t mode;
    logic               lo_tick, hi_tick, inc16, hi_inc;
    logic               hovf, lovf, cap_evt;

    always_comb begin
        mode    = mode_of(ctrl);
        lo_tick = src_tick(ctrl.low_byte_clock_select, ctrl.external_clock_select,
                           sys_tick_q, ext_tick_q);
        hi_tick = src_tick(ctrl.high_byte_clock_select, ctrl.external_clock_select,
                           sys_tick_q, ext_tick_q);
        inc16   = ctrl.run_control & lo_tick;
        hi_inc  = ctrl.run_control & hi_tick;
        cap_evt = ctrl.capture_enable &
                  (ctrl.capture_source_select ? lfo_fall : usb_sof);
        count_d = count_q;
        reload_d = reload_q;
        hovf    = 1'b0;
        lovf    = 1'b0;
        case (mode)
            rct_pkg::RCT_MODE_AR16, rct_pkg::RCT_MODE_CAP16: begin
                if (inc16) begin
                    lovf = (count_q.low == rct_pkg::BYTE_MAX);
                    hovf = (count_q == rct_pkg::WORD_MAX);
                    if (hovf && mode == rct_pkg::RCT_MODE_AR16) begin
                        count_d = reload_q;
                    end else begin
                        count_d = count_q + 16'h0001;
                    end
                end
            end
            rct_pkg::RCT_MODE_SPLIT, rct_pkg::RCT_MODE_CAPSP: begin
                if (lo_tick) begin
                    lovf = (count_q.low == rct_pkg::BYTE_MAX);
                    count_d.low = count_q.low + 8'h01;
                    if (lovf && mode == rct_pkg::RCT_MODE_SPLIT) begin
                        count_d.low = reload_q.low;
                    end
                end
                if (hi_inc) begin
                    hovf = (count_q.high == rct_pkg::BYTE_MAX);
                    count_d.high = count_q.high + 8'h01;
                    if (hovf && mode == rct_pkg::RCT_MODE_SPLIT) begin
                        count_d.high = reload_q.high;
                    end
                end
            end
            default: count_d = count_q;
        endcase
        if (count_wr) begin
            count_d = count_wdata;
        end
        if (reload_wr) begin
            reload_d = reload_wdata;
        end
        if (cap_evt) begin
            reload_d = count_q;
        end
        hflag_d = hovf | (hflag_q & ~high_flag_clear);
        lflag_d = lovf | (lflag_q & ~low_flag_clear);
        irq_d   = ctrl.timer_irq_enable &
                  (hovf | (ctrl.low_overflow_irq_enable & lovf) | cap_evt);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q  <= {rct_pkg::COUNT_RST, rct_pkg::COUNT_RST};
            reload_q <= {rct_pkg::RELOAD_RST, rct_pkg::RELOAD_RST};
            hflag_q  <= 1'b0;
            lflag_q  <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            count_q  <= count_d;
            reload_q <= reload_d;
            hflag_q  <= hflag_d;
            lflag_q  <= lflag_d;
            irq_q    <= irq_d;
        end
    end

    assign count_low_byte     = count_q.low;
    assign count_high_byte    = count_q.high;
    assign reload_low_byte    = reload_q.low;
    assign reload_high_byte   = reload_q.high;
    assign high_overflow_flag = hflag_q;
    assign low_overflow_flag  = lflag_q;
    assign timer_irq          = irq_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_quiet6;
        !sys_tick_q [*6];
    endsequence
    sequence s_quiet5_tick;
        !sys_tick_q [*5] ##1 sys_tick_q;
    endsequence
    sequence s_ovf16;
        mode == rct_pkg::RCT_MODE_AR16 && inc16 && count_q == rct_pkg::WORD_MAX;
    endsequence
    sequence s_split_hi_wrap;
        ctrl.split_mode_enable && hi_inc && count_q.high == rct_pkg::BYTE_MAX;
    endsequence
    sequence s_split_lo_wrap;
        ctrl.split_mode_enable && lo_tick && count_q.low == rct_pkg::BYTE_MAX;
    endsequence

    // Prescaler periods and idle hold
    a_sys_div_period: assert property (sys_tick_q |=> s_quiet6 ##1 s_quiet5_tick)
        else $error("system clock divider period wrong");
    a_ext_tick_gap: assert property (ext_tick_q |=> !ext_tick_q [*7])
        else $error("external tick too frequent");
    a_idle_hold: assert property (!ctrl.split_mode_enable && !inc16 && !count_wr
        |=> $stable({count_high_byte, count_low_byte}))
        else $error("16-bit count moved without a count enable");

    // 16-bit auto-reload
    a_wrap_reload: assert property (s_ovf16 ##0 !count_wr
        |=> count_q == $past(reload_q) && high_overflow_flag)
        else $error("16-bit wrap did not reload or flag");
    a_ovf16_irq: assert property (s_ovf16 ##0 ctrl.timer_irq_enable |=> timer_irq)
        else $error("16-bit overflow missed interrupt");
    a_low_wrap_irq: assert property (mode == rct_pkg::RCT_MODE_AR16 && inc16
        && count_q.low == rct_pkg::BYTE_MAX && ctrl.timer_irq_enable && ctrl.low_overflow_irq_enable
        |=> timer_irq && low_overflow_flag)
        else $error("low byte wrap missed interrupt");
    a_irq_cause: assert property (!hovf && !lovf && !cap_evt |=> !timer_irq)
        else $error("interrupt without an event");

    // Split mode
    a_split_reload: assert property (mode == rct_pkg::RCT_MODE_SPLIT && lo_tick && !count_wr
        && count_q.low == rct_pkg::BYTE_MAX |=> count_q.low == $past(reload_q.low))
        else $error("split low byte did not reload");
    a_high_gated: assert property (ctrl.split_mode_enable && !ctrl.run_control && !count_wr
        |=> $stable(count_q.high))
        else $error("high byte moved without run control");
    a_low_free: assert property (ctrl.split_mode_enable && lo_tick && !count_wr
        && count_q.low != rct_pkg::BYTE_MAX |=> count_q.low == $past(count_q.low) + 8'h01)
        else $error("split low byte did not count");
    a_split_flags: assert property (s_split_hi_wrap |=> high_overflow_flag)
        else $error("split high wrap did not set flag");
    a_split_irq: assert property (s_split_hi_wrap ##0 ctrl.timer_irq_enable |=> timer_irq)
        else $error("split high wrap missed interrupt");
    a_split_low_irq: assert property (s_split_lo_wrap ##0 ctrl.timer_irq_enable
        && ctrl.low_overflow_irq_enable |=> timer_irq && low_overflow_flag)
        else $error("split low wrap missed interrupt");

    // Flags
    a_flag_sticky: assert property (high_overflow_flag && !high_flag_clear |=> high_overflow_flag)
        else $error("high flag cleared without software");
    a_low_sticky: assert property (low_overflow_flag && !low_flag_clear |=> low_overflow_flag)
        else $error("low flag cleared without software");
    a_high_clear: assert property (high_overflow_flag && high_flag_clear && !hovf
        |=> !high_overflow_flag)
        else $error("high flag did not clear");
    a_low_clear: assert property (low_overflow_flag && low_flag_clear && !lovf
        |=> !low_overflow_flag)
        else $error("low flag did not clear");

    // Capture
    a_capture_copy: assert property (cap_evt |=> {reload_high_byte, reload_low_byte} == $past(count_q))
        else $error("capture did not copy count");
    a_capture_irq: assert property (cap_evt && ctrl.timer_irq_enable |=> timer_irq)
        else $error("capture did not raise interrupt");
    a_capsp_wrap: assert property (mode == rct_pkg::RCT_MODE_CAPSP && lo_tick && !count_wr
        && count_q.low == rct_pkg::BYTE_MAX |=> count_low_byte == 8'h00)
        else $error("capture split low byte did not wrap to zero");

endmodule

// File: test/rct_far_end.sv
// Far-side model: USB start-of-frame source and free-running oscillators.
// Assumes the bench requests a frame start by holding sof_req for one cycle.
`timescale 1ns/10ps
module rct_far_end #(
    parameter int EXT_HALF_NS = 15,
    parameter int LFO_HALF_NS = 100
) (
    input  wire logic clk,
    input  wire logic sof_req,
    output logic      usb_sof,
    output logic      ext_osc_clk,
    output logic      low_freq_osc
);
    // Oscillators run free; a 2 ns offset keeps their edges off the clk edges
    initial begin
        ext_osc_clk = 1'b0;
        #2;
        forever #(EXT_HALF_NS) ext_osc_clk = ~ext_osc_clk;
    end

    initial begin
        low_freq_osc = 1'b1;
        #2;
        forever #(LFO_HALF_NS) low_freq_osc = ~low_freq_osc;
    end

    // Frame start is a one-cycle synchronous pulse
    always @(posedge clk) begin
        usb_sof <= sof_req;
    end
endmodule

// File: test/reload_capture_timer16_tb.sv
// Self-checking bench for the reload/capture timer.
// Assumes rct_pkg and rct_timer compiled first; drives inputs on falling edges.
`timescale 1ns/10ps
module reload_capture_timer16_tb;
    typedef struct {
        int          id;
        logic [15:0] val;
    } rct_note_t;

    logic               clk;
    logic               resetn;
    logic               count_wr;
    logic               reload_wr;
    logic               high_flag_clear;
    logic               low_flag_clear;
    logic               sof_req;
    rct_pkg::rct_ctrl_t ctrl;
    rct_pkg::rct_pair_t count_wdata;
    rct_pkg::rct_pair_t reload_wdata;
    wire logic          ext_osc_clk;
    wire logic          usb_sof;
    wire logic          low_freq_osc;
    logic [7:0]         cl;
    logic [7:0]         ch;
    logic [7:0]         rl;
    logic [7:0]         rh;
    logic               hf;
    logic               lf;
    logic               irq;
    int                 error_cnt;
    int                 samples_checked;
    int                 irq_cnt;
    int                 cycles;
    logic [31:0]        r;
    rct_note_t          notes[$];
    string              what[4] = '{"count", "reload", "flags", "irq_count"};

    rct_timer rct_timer_i (.clk(clk), .resetn(resetn), .ctrl(ctrl), .count_wr(count_wr),
        .count_wdata(count_wdata), .reload_wr(reload_wr), .reload_wdata(reload_wdata),
        .high_flag_clear(high_flag_clear), .low_flag_clear(low_flag_clear),
        .ext_osc_clk(ext_osc_clk), .usb_sof(usb_sof), .low_freq_osc(low_freq_osc),
        .count_low_byte(cl), .count_high_byte(ch), .reload_low_byte(rl),
        .reload_high_byte(rh), .high_overflow_flag(hf), .low_overflow_flag(lf), .timer_irq(irq));

    rct_far_end rct_far_end_i (.clk(clk), .sof_req(sof_req), .usb_sof(usb_sof),
        .ext_osc_clk(ext_osc_clk), .low_freq_osc(low_freq_osc));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Interrupt pulses and hang guard
    always @(posedge clk) begin
        cycles++;
        if (irq === 1'b1) irq_cnt++;
        if (cycles == 6000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // Watcher: compares oldest note with what the outputs show
    initial begin
        rct_note_t   n;
        logic [15:0] seen;
        forever begin
            @(negedge clk);
            #1;
            while (notes.size() > 0) begin
                n = notes.pop_front();
                case (n.id)
                    0: seen = {ch, cl};
                    1: seen = {rh, rl};
                    2: seen = {14'h0000, hf, lf};
                    default: seen = irq_cnt[15:0];
                endcase
                samples_checked++;
                if (seen !== n.val) begin
                    error_cnt++;
                    $display("unexpected %s: expected %h, seen %h", what[n.id], n.val, seen);
                end
            end
        end
    end

    task note(int id, logic [15:0] v);
        notes.push_back('{id: id, val: v});
    endtask

    task cyc(int k);
        repeat (k) @(negedge clk);
    endtask

    task wr_count(logic [15:0] v);
        count_wdata = v;
        count_wr = 1'b1;
        cyc(1);
        count_wr = 1'b0;
    endtask

    task wr_reload(logic [15:0] v);
        reload_wdata = v;
        reload_wr = 1'b1;
        cyc(1);
        reload_wr = 1'b0;
    endtask

    task run(int k);
        ctrl.run_control = 1'b1;
        cyc(k);
        ctrl.run_control = 1'b0;
    endtask

    initial begin
        {ctrl, count_wr, reload_wr, high_flag_clear, low_flag_clear, sof_req} = '0;
        count_wdata = '0;
        reload_wdata = '0;
        resetn = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        irq_cnt = 0;
        cycles = 0;
        r = $urandom(97);
        cyc(3);
        resetn = 1'b1;
        cyc(4);
        note(0, 16'h0000);
        note(1, 16'h0000);
        note(2, 16'h0000);
        // 16-bit reload, every cycle
        ctrl.timer_irq_enable = 1'b1;
        ctrl.low_overflow_irq_enable = 1'b1;
        ctrl.low_byte_clock_select = 1'b1;
        wr_count(16'hFEFF);
        wr_reload(16'h1234);
        run(1);
        cyc(1);
        note(0, 16'hFF00);
        note(2, 16'h0001);
        note(3, 16'h0001);
        run(256);
        cyc(1);
        note(0, 16'h1234);
        note(2, 16'h0003);
        note(3, 16'h0002);
        high_flag_clear = 1'b1;
        cyc(1);
        high_flag_clear = 1'b0;
        note(2, 16'h0001);
        low_flag_clear = 1'b1;
        cyc(1);
        low_flag_clear = 1'b0;
        note(2, 16'h0000);
        // Divided-by-12 source
        ctrl.low_byte_clock_select = 1'b0;
        wr_count(16'h0000);
        run(24);
        note(0, 16'h0002);
        // Split mode
        ctrl.split_mode_enable = 1'b1;
        ctrl.high_byte_clock_select = 1'b1;
        ctrl.low_byte_clock_select = 1'b1;
        wr_reload(16'hAA55);
        wr_count(16'h20FE);
        cyc(2);
        note(0, 16'h2055);
        note(2, 16'h0001);
        run(1);
        note(0, 16'h2156);
        note(3, 16'h0003);
        ctrl.low_overflow_irq_enable = 1'b0;
        wr_count(16'hFF00);
        run(1);
        note(0, 16'hAA01);
        note(2, 16'h0003);
        cyc(1);
        note(3, 16'h0004);
        // External divided-by-8 source in 16-bit mode
        ctrl = '0;
        ctrl.external_clock_select = 1'b1;
        wr_count(16'h0000);
        run(48);
        note(0, 16'h0002);
        // Capture with split: free-running low byte wraps, no reload
        ctrl.capture_enable = 1'b1;
        ctrl.split_mode_enable = 1'b1;
        ctrl.timer_irq_enable = 1'b1;
        ctrl.low_byte_clock_select = 1'b1;
        wr_count(16'h12FE);
        cyc(2);
        note(0, 16'h1200);
        sof_req = 1'b1;
        cyc(1);
        sof_req = 1'b0;
        cyc(1);
        note(1, 16'h1201);
        // Capture on frame start, then on oscillator fall
        ctrl = '0;
        ctrl.capture_enable = 1'b1;
        ctrl.timer_irq_enable = 1'b1;
        r = $urandom;
        wr_count(r[15:0]);
        sof_req = 1'b1;
        cyc(1);
        sof_req = 1'b0;
        cyc(2);
        note(1, r[15:0]);
        note(3, 16'h0006);
        ctrl.capture_source_select = 1'b1;
        r = $urandom;
        wr_count(r[15:0]);
        cyc(30);
        note(1, r[15:0]);
        cyc(2);
        give_verdict();
    end
endmodule
